// File: core/rcb_pkg.sv
/*
 * Constants, types and carriers of the rate compare elastic buffer.
 * Assumes one 200 MHz clock; channel pins are asynchronous to it.
 */
package rcb_pkg;
    localparam int ADDR_W = 4;
    localparam int STORE_DEPTH = 16;
    localparam int WORD_CNT_W = 10;
    localparam int FIFO_DEPTH = 2;
    localparam logic [3:0] RD_RESET_VAL = 4'h0;
    localparam logic [3:0] WR_PRESET_VAL = 4'hA;
    localparam logic [3:0] NOMINAL_OFFSET = 4'h8;
    localparam logic [3:0] OOT_LOW_LIMIT = 4'h2;
    localparam logic [3:0] OOT_HIGH_LIMIT = 4'hE;
    localparam logic [1:0] PRESET_DELAY_CYC = 2'h2;
    localparam int CLK_HZ = 200_000_000;
    localparam int CHAN_MAX_BPS = 3_000_000;
    localparam int CHAN_MIN_BPS = 50;
    // clock cycles per channel bit at the fastest rate, rounded down
    localparam int CYC_PER_FAST_BIT = CLK_HZ / CHAN_MAX_BPS;

    typedef enum logic {
        DIRECT_CLOCK_MODE = 1'b0,
        COARSE_CONVERSION_MODE = 1'b1
    } clock_mode_t;

    typedef enum logic [1:0] {
        CMP_IDLE = 2'b00,
        CMP_ARMED = 2'b01,
        CMP_RESET_WAIT = 2'b10,
        CMP_PRESET = 2'b11
    } compare_state_t;

    typedef struct packed {
        logic pos;
        logic neg;
        logic out_of_tolerance_decode;
    } stuff_decode_t;

    typedef struct packed {
        logic word24_bit0;
        logic end_of_scan;
        logic major_frame_end;
        logic overhead_slot;
    } frame_strobe_t;
endpackage

// File: core/rate_compare_elastic_buffer.sv
/*
 * Channel rate compare elastic buffer: serial channel bits are written on
 * their own timing into a 16-bit store and read out on gated clocks.
 * Assumes the multiplexer strobes and gated clocks are one-cycle pulses on
 * clk and that the gated clock source holds clocks while the ready is low.
 */
`timescale 1ns/100ps
module rate_compare_elastic_buffer
    import rcb_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // channel pins
    input wire logic channel_data_in,
    input wire logic channel_timing_in,
    // static configuration
    input wire logic mode_select_switch,
    input wire logic [WORD_CNT_W-1:0] fill_bit_straps,
    // multiplexer timing
    input wire logic gated_read_clock,
    input wire frame_strobe_t frame_strobes,
    output logic read_clock_ready,
    // stuff requests
    output logic positive_stuff_request,
    output logic negative_stuff_request,
    output logic out_of_tolerance,
    // diagnostics
    output logic channel_timing_tick,
    // synchronous data out
    output logic out_valid,
    input wire logic out_ready,
    output logic out_data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic t_s1_ff, t_s2_ff, t_s3_ff;
    logic d_s1_ff, d_s2_ff, m_s1_ff, m_s2_ff;
    logic tick, tick_ff;
    logic [ADDR_W-1:0] wr_addr_ff, nxt_wr_addr;
    logic in_buf_ff, nxt_in_buf;
    logic store_ff [STORE_DEPTH];
    logic [ADDR_W-1:0] rd_addr_ff, nxt_rd_addr;
    logic [WORD_CNT_W-1:0] word_cnt_ff, nxt_word_cnt, word_rev;
    logic del_armed_ff, nxt_del_armed;
    logic rd_clk_eff, rd_take, fifo_ready, pop;
    logic fifo_e0_ff, fifo_e1_ff, nxt_e0, nxt_e1;
    logic [1:0] fifo_cnt_ff, nxt_fifo_cnt;
    compare_state_t state_ff, nxt_state;
    clock_mode_t mode_ff, nxt_mode;
    stuff_decode_t decode_ff, nxt_decode;
    logic [ADDR_W-1:0] rd_latch_ff, nxt_rd_latch, wr_latch_ff, nxt_wr_latch, diff;
    logic [1:0] delay_ff, nxt_delay;
    logic reset_rd, preset_wr, reset_pending, oot_now;

    // two-stage synchronisers for the asynchronous pins
    always_ff @(posedge clk) begin
        t_s1_ff <= channel_timing_in;
        t_s2_ff <= t_s1_ff;
        t_s3_ff <= t_s2_ff;
        d_s1_ff <= channel_data_in;
        d_s2_ff <= d_s1_ff;
        m_s1_ff <= mode_select_switch;
        m_s2_ff <= m_s1_ff;
    end

    // rising edge of channel timing; 200 MHz oversamples even 3 Mbps
    assign tick = t_s2_ff & ~t_s3_ff;
    assign channel_timing_tick = tick_ff; // one-cycle pulse per edge, from a flop

    // write side: input buffer stage then serial write at the write address
    always_comb begin
        nxt_in_buf = in_buf_ff;
        nxt_wr_addr = wr_addr_ff;
        if (tick) begin
            nxt_in_buf = d_s2_ff;
            nxt_wr_addr = wr_addr_ff + 4'h1;
        end
        if (preset_wr) begin
            nxt_wr_addr = WR_PRESET_VAL;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            in_buf_ff <= 1'b0;
            wr_addr_ff <= WR_PRESET_VAL;
            tick_ff <= 1'b0;
        end else begin
            in_buf_ff <= nxt_in_buf;
            wr_addr_ff <= nxt_wr_addr;
            tick_ff <= tick;
        end
    end

    // elastic store: one write port and one read port at other addresses
    always_ff @(posedge clk) begin
        if (tick) begin
            store_ff[wr_addr_ff] <= in_buf_ff;
        end
    end

    // coarse conversion: reversed word count against straps spreads deletions
    always_comb begin
        word_rev = {<<{word_cnt_ff}};
        nxt_word_cnt = word_cnt_ff;
        nxt_del_armed = del_armed_ff;
        if (frame_strobes.major_frame_end) begin
            nxt_word_cnt = '0;
        end else if (frame_strobes.end_of_scan && !frame_strobes.overhead_slot) begin
            nxt_word_cnt = word_cnt_ff + 10'h001;
        end
        if (gated_read_clock && del_armed_ff && fifo_ready) begin
            nxt_del_armed = 1'b0; // one single clock removed per word
        end
        if (frame_strobes.end_of_scan) begin
            nxt_del_armed = (mode_ff == COARSE_CONVERSION_MODE)
                && !frame_strobes.overhead_slot && (word_rev > fill_bit_straps);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            word_cnt_ff <= '0;
            del_armed_ff <= 1'b0;
        end else begin
            word_cnt_ff <= nxt_word_cnt;
            del_armed_ff <= nxt_del_armed;
        end
    end

    // gated clocks pass straight in direct mode, via deletion in coarse mode
    assign rd_clk_eff = gated_read_clock
        & ~((mode_ff == COARSE_CONVERSION_MODE) & del_armed_ff);
    assign rd_take = rd_clk_eff & fifo_ready;
    assign read_clock_ready = fifo_ready;

    // read address counter
    always_comb begin
        nxt_rd_addr = rd_addr_ff;
        if (reset_rd) begin
            nxt_rd_addr = RD_RESET_VAL;
        end else if (rd_take) begin
            nxt_rd_addr = rd_addr_ff + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_addr_ff <= RD_RESET_VAL;
        end else begin
            rd_addr_ff <= nxt_rd_addr;
        end
    end

    // two-entry output buffer; head entry drives the data pin directly
    assign pop = out_valid & out_ready;
    assign out_valid = (fifo_cnt_ff != 2'h0);
    assign fifo_ready = (fifo_cnt_ff != 2'(FIFO_DEPTH));
    assign out_data = fifo_e0_ff;

    always_comb begin
        nxt_e0 = fifo_e0_ff;
        nxt_e1 = fifo_e1_ff;
        nxt_fifo_cnt = fifo_cnt_ff;
        if (pop) begin
            nxt_e0 = fifo_e1_ff;
            nxt_fifo_cnt = fifo_cnt_ff - 2'h1;
        end
        if (rd_take) begin
            if (nxt_fifo_cnt == 2'h0) begin
                nxt_e0 = store_ff[rd_addr_ff];
            end else begin
                nxt_e1 = store_ff[rd_addr_ff];
            end
            nxt_fifo_cnt = nxt_fifo_cnt + 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fifo_e0_ff <= 1'b0;
            fifo_e1_ff <= 1'b0;
            fifo_cnt_ff <= 2'h0;
        end else begin
            fifo_e0_ff <= nxt_e0;
            fifo_e1_ff <= nxt_e1;
            fifo_cnt_ff <= nxt_fifo_cnt;
        end
    end

    // rate compare, decode and initialization sequence
    assign diff = wr_addr_ff - rd_latch_ff; // write lead over read
    assign oot_now = (diff <= OOT_LOW_LIMIT) || (diff >= OOT_HIGH_LIMIT);
    assign reset_pending = (state_ff == CMP_RESET_WAIT) || (state_ff == CMP_PRESET);
    assign reset_rd = (state_ff == CMP_RESET_WAIT) && frame_strobes.word24_bit0;
    assign preset_wr = (state_ff == CMP_PRESET) && (delay_ff == PRESET_DELAY_CYC - 2'h1);

    always_comb begin
        nxt_state = state_ff;
        nxt_rd_latch = rd_latch_ff;
        nxt_wr_latch = wr_latch_ff;
        nxt_decode = decode_ff;
        nxt_delay = delay_ff;
        nxt_mode = mode_ff;
        if (reset_pending) begin
            nxt_mode = clock_mode_t'(m_s2_ff);
        end
        unique case (state_ff)
            CMP_IDLE: begin
                if (frame_strobes.word24_bit0) begin
                    nxt_rd_latch = rd_addr_ff;
                    nxt_state = CMP_ARMED;
                end
            end
            CMP_ARMED: begin
                if (tick) begin
                    nxt_wr_latch = wr_addr_ff;
                    nxt_decode.out_of_tolerance_decode = oot_now;
                    nxt_decode.pos = !oot_now && (diff > NOMINAL_OFFSET);
                    nxt_decode.neg = !oot_now && (diff < NOMINAL_OFFSET);
                    nxt_state = oot_now ? CMP_RESET_WAIT : CMP_IDLE;
                end
            end
            CMP_RESET_WAIT: begin
                nxt_decode.pos = 1'b0;
                nxt_decode.neg = 1'b0;
                if (frame_strobes.word24_bit0) begin
                    nxt_delay = 2'h0;
                    nxt_state = CMP_PRESET;
                end
            end
            CMP_PRESET: begin
                nxt_delay = delay_ff + 2'h1;
                if (preset_wr) begin
                    nxt_decode.out_of_tolerance_decode = 1'b0;
                    nxt_state = CMP_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= CMP_RESET_WAIT;
            rd_latch_ff <= RD_RESET_VAL;
            wr_latch_ff <= WR_PRESET_VAL;
            decode_ff <= '0;
            delay_ff <= 2'h0;
            mode_ff <= DIRECT_CLOCK_MODE;
        end else begin
            state_ff <= nxt_state;
            rd_latch_ff <= nxt_rd_latch;
            wr_latch_ff <= nxt_wr_latch;
            decode_ff <= nxt_decode;
            delay_ff <= nxt_delay;
            mode_ff <= nxt_mode;
        end
    end

    // requests stand in both modes; partner stuffs in its overhead slot
    assign positive_stuff_request = decode_ff.pos;
    assign negative_stuff_request = decode_ff.neg;
    assign out_of_tolerance = decode_ff.out_of_tolerance_decode;

    // checks on the block's own behaviour
    sequence s_oot_reset;
        (state_ff == CMP_RESET_WAIT) && frame_strobes.word24_bit0;
    endsequence

    sequence s_compare_load;
        (state_ff == CMP_IDLE) && frame_strobes.word24_bit0;
    endsequence

    AST_WR_ADVANCE: assert property (tick && !preset_wr |=>
        wr_addr_ff == $past(wr_addr_ff) + 4'h1)
        else $error("write address did not advance on timing tick");

    AST_STORE_WRITE: assert property (tick |=>
        store_ff[$past(wr_addr_ff)] == $past(in_buf_ff))
        else $error("input buffer bit not written to store");

    AST_RD_ADVANCE: assert property (rd_take && !reset_rd |=>
        rd_addr_ff == $past(rd_addr_ff) + 4'h1)
        else $error("read address did not advance on gated clock");

    AST_DIRECT_PASS: assert property ((mode_ff == DIRECT_CLOCK_MODE)
        && gated_read_clock && fifo_ready |-> rd_take)
        else $error("gated clock not passed in direct mode");

    AST_COARSE_DELETE: assert property ((mode_ff == COARSE_CONVERSION_MODE)
        && gated_read_clock && del_armed_ff |-> !rd_take ##1 !del_armed_ff)
        else $error("coarse deletion did not remove one gated clock");

    AST_LATCH_READ: assert property (s_compare_load |=>
        (rd_latch_ff == $past(rd_addr_ff)) && (state_ff == CMP_ARMED))
        else $error("read address not latched at word 24 bit 0");

    AST_LATCH_BLOCKED: assert property (reset_pending |=>
        $stable(rd_latch_ff) && $stable(wr_latch_ff))
        else $error("address latch loaded while reset pending");

    AST_DECODE: assert property ((state_ff == CMP_ARMED) && tick |=>
        decode_ff.pos == (!$past(oot_now) && ($past(diff) > NOMINAL_OFFSET))
        && decode_ff.neg == (!$past(oot_now) && ($past(diff) < NOMINAL_OFFSET)))
        else $error("stuff decode does not match latched difference");

    AST_OOT_RESET: assert property (s_oot_reset |=>
        (rd_addr_ff == RD_RESET_VAL) ##2 (wr_addr_ff == WR_PRESET_VAL))
        else $error("out of tolerance reset or preset mistimed");

    AST_FIFO_COUNT: assert property (rd_take && !pop |=>
        fifo_cnt_ff == $past(fifo_cnt_ff) + 2'h1)
        else $error("read bit not buffered");

    AST_MODE_STATIC: assert property (!reset_pending |=> $stable(mode_ff))
        else $error("mode changed outside initialization");
endmodule

// File: testbench/gated_clock_source_model.sv
/*
 * Behavioural gated clock source that feeds the elastic buffer.
 * Assumes clk domain commands from the bench and a bench-driven overhead slot level.
 */
`timescale 1ns/100ps
module gated_clock_source_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bench commands
    input wire logic run,
    input wire logic shot,
    input wire logic ignore_ready,
    // buffer side
    input wire logic read_clock_ready,
    input wire logic positive_stuff_request,
    input wire logic negative_stuff_request,
    input wire logic overhead_slot,
    output logic gated_read_clock
);
    logic [3:0] phase_ff;
    logic slot_ff;
    logic drop_ff;
    logic want;
    logic slot_start;

    // base rate of one clock per 16 cycles; an extra clock only at slot start
    assign slot_start = overhead_slot & ~slot_ff;
    assign want = shot | (run & (phase_ff == 4'hF)) | (slot_start & positive_stuff_request);

    // phase counter and the slot-bound deletion flag
    always_ff @(posedge clk) begin
        if (rst) begin
            phase_ff <= 4'h0;
            slot_ff <= 1'b0;
            drop_ff <= 1'b0;
        end
        else begin
            phase_ff <= phase_ff + 4'h1;
            slot_ff <= overhead_slot;
            drop_ff <= overhead_slot & ~(want & drop_ff) & (drop_ff | (slot_start & negative_stuff_request));
        end
    end

    // holds clocks while the buffer is full unless told to misbehave
    assign gated_read_clock = want & ~drop_ff & (read_clock_ready | ignore_ready);
endmodule

// File: testbench/testbench.sv
/*
 * Self-checking bench of the rate compare elastic buffer.
 * Assumes the package constants and the gated clock source model beside it.
 */
`timescale 1ns/100ps
module testbench;
    import rcb_pkg::*;
    typedef struct {int t; int g; logic [2:0] exp;} row_t;
    localparam logic [15:0] PATTERN = 16'h4D2F;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic chan_data = 1'b0;
    logic chan_time = 1'b0;
    logic mode = 1'b0;
    logic run = 1'b0;
    logic shot = 1'b0;
    logic blind = 1'b0;
    logic ordy = 1'b1;
    logic [WORD_CNT_W-1:0] straps = '0;
    frame_strobe_t fs = '0;
    logic gclk, rc_ready, pos, neg, out_of_tolerance_decode, tick, ovalid, odata;
    int fail_count = 0;
    int checks = 0;
    int ticks = 0;
    logic popped[$];
    // rows: channel ticks, gated clocks, expected {pos, neg, oot}
    row_t rows[5] = '{'{0, 0, 3'b100}, '{0, 2, 3'b000}, '{0, 5, 3'b010}, '{4, 0, 3'b001},
        '{0, 9, 3'b001}};

    always #2.5 clk = ~clk;

    rate_compare_elastic_buffer uut (.clk(clk), .rst(rst), .channel_data_in(chan_data),
        .channel_timing_in(chan_time), .mode_select_switch(mode), .fill_bit_straps(straps),
        .gated_read_clock(gclk), .frame_strobes(fs), .read_clock_ready(rc_ready),
        .positive_stuff_request(pos), .negative_stuff_request(neg), .out_of_tolerance(out_of_tolerance_decode),
        .channel_timing_tick(tick), .out_valid(ovalid), .out_ready(ordy), .out_data(odata));
    gated_clock_source_model partner (.clk(clk), .rst(rst), .run(run), .shot(shot),
        .ignore_ready(blind), .read_clock_ready(rc_ready), .positive_stuff_request(pos),
        .negative_stuff_request(neg), .overhead_slot(fs.overhead_slot), .gated_read_clock(gclk));

    // collect popped bits and diagnostic ticks
    always @(posedge clk) begin
        if (ovalid === 1'b1 && ordy === 1'b1) popped.push_back(odata);
        if (tick === 1'b1) ticks++;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic pulse(input int i);
        @(negedge clk) fs[i] = 1'b1;
        @(negedge clk) fs[i] = 1'b0;
    endtask

    // single gated clocks, spaced so the output buffer keeps room
    task automatic shots(input int n);
        repeat (n) begin
            @(negedge clk) shot = 1'b1;
            @(negedge clk) shot = 1'b0;
            cycles(2);
        end
    endtask

    // link clock of 80 ns, still between frames; data line flips once released
    task automatic chan_bits(input int n);
        #1.3;
        for (int k = 0; k < n; k++) begin
            chan_data = PATTERN[15 - (k % 16)];
            #20 chan_time = 1'b1;
            #40 chan_time = 1'b0;
            #20 chan_data = ~chan_data;
        end
        cycles(1);
    endtask

    task automatic init(input logic m, input logic [WORD_CNT_W-1:0] s);
        rst = 1'b1;
        mode = m;
        straps = s;
        cycles(12);
        rst = 1'b0;
        pulse(3);
        cycles(4);
    endtask

    // word 24 strobe, then one channel tick closes the compare
    task automatic compare();
        pulse(3);
        chan_bits(1);
        cycles(4);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end
        else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #200000;
        fail_count++;
        close_out();
    end

    initial begin
        int n;
        bit ok;
        bit hit;
        init(1'b0, '0);
        check(8'({ovalid, pos, neg, out_of_tolerance_decode, tick, rc_ready}), 8'h01, "idle outputs");
        // ordinary compares from a fresh start
        foreach (rows[i]) begin
            init(1'b0, '0);
            shots(rows[i].g);
            ticks = 0;
            chan_bits(rows[i].t);
            check(8'(ticks), 8'(rows[i].t), "tick count");
            compare();
            check(8'({pos, neg, out_of_tolerance_decode}), 8'(rows[i].exp), "decode");
        end
        // recovery from out of tolerance restores the offset
        pulse(3);
        cycles(4);
        check(8'(out_of_tolerance_decode), 8'h00, "oot cleared");
        compare();
        check(8'({pos, neg, out_of_tolerance_decode}), 8'h04, "offset restored");
        // partner adds a clock in the overhead slot
        n = popped.size();
        fs[0] = 1'b1;
        cycles(4);
        fs[0] = 1'b0;
        cycles(4);
        check(8'(popped.size() - n), 8'h01, "stuffed clock");
        // stalled consumer: buffer fills, refuses, then drains whole
        ordy = 1'b0;
        blind = 1'b1;
        n = popped.size();
        shots(3);
        check(8'(rc_ready), 8'h00, "buffer full");
        ordy = 1'b1;
        blind = 1'b0;
        cycles(4);
        check(8'(popped.size() - n), 8'h02, "buffer drained");
        check(8'(ovalid), 8'h00, "buffer empty");
        // partner removes a clock in the overhead slot on a negative request
        init(1'b0, '0);
        shots(5);
        compare();
        check(8'({pos, neg, out_of_tolerance_decode}), 8'h02, "negative request");
        n = popped.size();
        fs[0] = 1'b1;
        shots(1);
        fs[0] = 1'b0;
        cycles(4);
        check(8'(popped.size() - n), 8'h00, "removed clock");
        shots(1);
        cycles(2);
        check(8'(popped.size() - n), 8'h01, "clock after slot");
        // coarse with low straps deletes; high straps and direct mode pass all
        for (int c = 0; c < 3; c++) begin
            init(c != 2, (c == 1) ? '1 : '0);
            n = popped.size();
            repeat (6) begin
                pulse(2);
                shots(1);
            end
            // word 0 reverses to 0, not above zero straps, so one clock passes
            check(8'(popped.size() - n), c ? 8'h06 : 8'h01, "coarse");
        end
        // equal rates in step: last reads are one contiguous run of the pattern
        init(1'b0, '0);
        fork
            chan_bits(48);
            begin
                run = 1'b1;
                #3840 run = 1'b0;
            end
        join
        cycles(20);
        n = popped.size();
        hit = 1'b0;
        for (int r = 0; r < 16 && n >= 26; r++) begin
            ok = 1'b1;
            for (int k = 0; k < 16; k++) if (popped[n - 16 + k] !== PATTERN[15 - ((k + r) % 16)]) ok = 1'b0;
            if (ok) hit = 1'b1;
        end
        check(8'(hit), 8'h01, "bit integrity");
        close_out();
    end
endmodule
